// *** shared/adc_pkg.sv ***
// package of constants and types for the converter sequencer
package adc_pkg;
    // ====================================================================
    // register map (byte addresses on the plain register port)
    localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_RESULT = 2'h1;
    localparam logic [1:0] ADDR_CLOCK_SELECT = 2'h2;

    // ====================================================================
    // status/control field positions
    localparam int DONE_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int CONT_BIT = 5;
    localparam int CHAN_MSB = 4;
    // clock select field positions
    localparam int PRESCALE_MSB = 7;
    localparam int PRESCALE_LSB = 5;
    localparam int SOURCE_BIT = 4;

    // ====================================================================
    // reset values
    localparam logic [4:0] CHAN_RESET = 5'h1F;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;
    localparam logic SOURCE_RESET = 1'b0;

    // ====================================================================
    // channel codes
    localparam logic [4:0] CHAN_PORT_B_LAST = 5'h07;
    localparam logic [4:0] CHAN_PORT_D_FIRST = 5'h08;
    localparam logic [4:0] CHAN_PORT_D_LAST = 5'h0E;
    localparam logic [4:0] CHAN_RESERVED = 5'h1B;
    localparam logic [4:0] CHAN_REF_HIGH = 5'h1D;
    localparam logic [4:0] CHAN_REF_LOW = 5'h1E;
    localparam logic [4:0] CHAN_POWER_OFF = 5'h1F;
    localparam int CHANNELS_SMALL = 8;
    localparam int CHANNELS_FULL = 15;

    // ====================================================================
    // prescaler codes and divider terminal counts
    localparam logic [2:0] DIV1_CODE = 3'h0;
    localparam logic [2:0] DIV2_CODE = 3'h1;
    localparam logic [2:0] DIV4_CODE = 3'h2;
    localparam logic [2:0] DIV8_CODE = 3'h3;
    localparam logic [3:0] DIV1_LAST = 4'h0;
    localparam logic [3:0] DIV2_LAST = 4'h1;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [3:0] DIV8_LAST = 4'h7;
    localparam logic [3:0] DIV16_LAST = 4'hF;

    // ====================================================================
    // conversion timing in converter clocks
    localparam logic [2:0] SAMPLE_LAST = 3'h6;
    localparam logic [7:0] TRIAL_FIRST = 8'h80;
    localparam logic [7:0] TRIAL_LAST = 8'h01;

    // ====================================================================
    // types
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic power_on;
        logic [4:0] channel;
        logic sample;
        logic [7:0] trial_code;
    } analog_ctl_t;
endpackage

// *** hdl/adc_sequencer_control.sv ***
// control, status and successive-approximation sequencer of the 8-bit converter
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module adc_sequencer_control
    import adc_pkg::*;
#(
    parameter int CHANNELS = 15
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire adc_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // clock source and low power modes
    input wire logic osc_tick,
    input wire logic wait_mode,
    input wire logic stop_mode,
    // analog multiplexer and comparator
    output adc_pkg::analog_ctl_t analog_ctl,
    input wire logic comparator_high,
    // port pin override
    output logic [7:0] port_b_adc_sel,
    output logic [6:0] port_d_adc_sel,
    // processor interrupt and wake
    output logic conv_irq,
    output logic wake_request
);
    import adc_pkg::*;

    // ====================================================================
    // functions

    // divider terminal count for a prescaler code
    function automatic logic [3:0] div_last(input logic [2:0] code);
        if (code == DIV1_CODE)
            return DIV1_LAST;
        else if (code == DIV2_CODE)
            return DIV2_LAST;
        else if (code == DIV4_CODE)
            return DIV4_LAST;
        else if (code == DIV8_CODE)
            return DIV8_LAST;
        else
            return DIV16_LAST;
    endfunction

    // one-hot pin select for a channel code, zero outside the range
    function automatic logic [7:0] pin_sel(input logic [4:0] chan, input logic [4:0] first,
                                           input logic [4:0] last);
        logic [4:0] idx;
        idx = 5'(chan - first);
        if (chan >= first && chan <= last)
            return 8'(8'h01 << idx[2:0]);
        else
            return 8'h00;
    endfunction

    // ====================================================================
    // declarations
    logic irq_enable_reg;
    logic continuous_reg;
    logic [4:0] channel_reg;
    logic conv_done_flag_reg;
    logic irq_pending_reg;
    logic first_pending_reg;
    logic [2:0] prescale_reg;
    logic source_reg;
    logic [7:0] result_reg;
    logic [7:0] sar_reg;
    logic [7:0] mask_reg;
    logic [2:0] step_reg;
    conv_state_t state_reg;
    logic [3:0] div_cnt_reg;
    logic go_reg;
    logic resume_reg;
    logic stop_d_reg;
    logic [7:0] rdata_reg;
    logic wr_status;
    logic wr_clock;
    logic rd_result;
    logic clear_evt;
    logic powered;
    logic in_tick;
    logic adc_tick;
    logic conv_done;
    logic stop_entry;
    logic stop_exit;
    logic [7:0] trial;

    // ====================================================================
    // register access decode
    always_comb
    begin
        wr_status = 1'b0;
        wr_clock = 1'b0;
        rd_result = 1'b0;
        if (reg_req.wr && reg_req.addr == ADDR_STATUS_CONTROL)
            wr_status = 1'b1;
        else if (reg_req.wr && reg_req.addr == ADDR_CLOCK_SELECT)
            wr_clock = 1'b1;
        else if (reg_req.rd && reg_req.addr == ADDR_RESULT)
            rd_result = 1'b1;
    end

    assign clear_evt = wr_status || rd_result;
    assign powered = (channel_reg != CHAN_POWER_OFF);
    assign stop_entry = stop_mode && !stop_d_reg;
    assign stop_exit = !stop_mode && stop_d_reg;
    // wait_mode is deliberately ignored: conversions carry on
    assign trial = sar_reg | mask_reg;

    // ====================================================================
    // control fields written by software
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_enable_reg <= 1'b0;
            continuous_reg <= 1'b0;
            channel_reg <= CHAN_RESET;
        end
        else if (wr_status)
        begin
            irq_enable_reg <= reg_req.wdata[IRQ_EN_BIT];
            continuous_reg <= reg_req.wdata[CONT_BIT];
            channel_reg <= reg_req.wdata[CHAN_MSB:0];
        end
    end

    // clock select register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prescale_reg <= PRESCALE_RESET;
            source_reg <= SOURCE_RESET;
        end
        else if (wr_clock)
        begin
            prescale_reg <= reg_req.wdata[PRESCALE_MSB:PRESCALE_LSB];
            source_reg <= reg_req.wdata[SOURCE_BIT];
        end
    end

    // ====================================================================
    // converter clock: source select then prescaler
    assign in_tick = source_reg ? 1'b1 : osc_tick;
    assign adc_tick = in_tick && (div_cnt_reg == div_last(prescale_reg)) && powered && !stop_mode;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt_reg <= 4'h0;
        else if (!powered || stop_mode)
            div_cnt_reg <= 4'h0; // no converter clock while off
        else if (in_tick)
            div_cnt_reg <= (div_cnt_reg >= div_last(prescale_reg)) ? 4'h0 : 4'(div_cnt_reg + 4'h1);
    end

    // ====================================================================
    // stop mode tracking
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            stop_d_reg <= 1'b0;
        else
            stop_d_reg <= stop_mode;
    end

    // remember whether work was cut off by stop
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            resume_reg <= 1'b0;
        else if (stop_entry)
            resume_reg <= go_reg || continuous_reg || (state_reg != ST_IDLE);
        else if (stop_exit || wr_status)
            resume_reg <= 1'b0;
    end

    // ====================================================================
    // conversion request
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            go_reg <= 1'b0;
        else if (wr_status)
            go_reg <= (reg_req.wdata[CHAN_MSB:0] != CHAN_POWER_OFF);
        else if (stop_exit && resume_reg)
            go_reg <= 1'b1;
        else if (conv_done && continuous_reg)
            go_reg <= 1'b1;
        else if (state_reg == ST_IDLE && adc_tick)
            go_reg <= 1'b0;
    end

    // ====================================================================
    // successive-approximation sequencer
    assign conv_done = (state_reg == ST_CONVERT) && adc_tick && (mask_reg == TRIAL_LAST) && !wr_status;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            step_reg <= 3'h0;
            sar_reg <= 8'h00;
            mask_reg <= 8'h00;
        end
        else if (stop_mode || wr_status || !powered)
        begin
            state_reg <= ST_IDLE;
            mask_reg <= 8'h00;
        end
        else if (adc_tick)
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    // first converter clock opens the sample phase
                    if (go_reg)
                    begin
                        state_reg <= ST_SAMPLE;
                        step_reg <= 3'h0;
                        sar_reg <= 8'h00;
                    end
                end
                ST_SAMPLE:
                begin
                    if (step_reg == SAMPLE_LAST)
                    begin
                        state_reg <= ST_CONVERT;
                        mask_reg <= TRIAL_FIRST;
                    end
                    else
                        step_reg <= 3'(step_reg + 3'h1);
                end
                ST_CONVERT:
                begin
                    // keep the trial bit when the input is at or above it
                    if (comparator_high)
                        sar_reg <= trial;
                    mask_reg <= mask_reg >> 1;
                    if (mask_reg == TRIAL_LAST)
                        state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // result register: last trial folded in at completion
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            result_reg <= 8'h00;
        else if (conv_done)
            result_reg <= comparator_high ? trial : sar_reg;
    end

    // ====================================================================
    // completion flag and interrupt request
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            first_pending_reg <= 1'b0;
        else if (wr_status)
            first_pending_reg <= 1'b1;
        else if (conv_done)
            first_pending_reg <= 1'b0;
    end

    // done flag: set wins over clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            conv_done_flag_reg <= 1'b0;
        else if (conv_done && !irq_enable_reg && (!continuous_reg || first_pending_reg))
            conv_done_flag_reg <= 1'b1;
        else if (clear_evt)
            conv_done_flag_reg <= 1'b0;
    end

    // interrupt request: set wins over clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            irq_pending_reg <= 1'b0;
        else if (conv_done && irq_enable_reg)
            irq_pending_reg <= 1'b1;
        else if (clear_evt)
            irq_pending_reg <= 1'b0;
    end

    assign conv_irq = irq_pending_reg;
    assign wake_request = irq_pending_reg;

    // ====================================================================
    // read data, one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= 8'h00;
        else if (reg_req.rd)
        begin
            if (reg_req.addr == ADDR_STATUS_CONTROL)
                rdata_reg <= {conv_done_flag_reg, irq_enable_reg, continuous_reg, channel_reg};
            else if (reg_req.addr == ADDR_RESULT)
                rdata_reg <= result_reg;
            else if (reg_req.addr == ADDR_CLOCK_SELECT)
                rdata_reg <= {prescale_reg, source_reg, 4'h0};
            else
                rdata_reg <= 8'h00; // unmapped
        end
    end

    assign reg_rdata = rdata_reg;

    // ====================================================================
    // analog side and pin override
    always_comb
    begin
        analog_ctl.power_on = powered && !stop_mode;
        analog_ctl.channel = channel_reg;
        analog_ctl.sample = (state_reg == ST_SAMPLE);
        analog_ctl.trial_code = (state_reg == ST_CONVERT) ? trial : 8'h00;
    end

    // pins in use by the converter are forced to analog input
    always_comb
    begin
        logic [7:0] d_sel;
        d_sel = pin_sel(channel_reg, CHAN_PORT_D_FIRST, CHAN_PORT_D_LAST);
        port_b_adc_sel = pin_sel(channel_reg, 5'h00, CHAN_PORT_B_LAST);
        port_d_adc_sel = (CHANNELS > CHANNELS_SMALL) ? d_sel[6:0] : 7'h00;
    end

endmodule // adc_sequencer_control

// *** tb/adc_seq_sva.sv ***
// port checker for the converter sequencer
`timescale 1ns/1ps
module adc_seq_sva
    import adc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port and modes
    input wire adc_pkg::reg_req_t reg_req,
    input wire logic stop_mode,
    // converter side and outputs
    input wire adc_pkg::analog_ctl_t analog_ctl,
    input wire logic [7:0] port_b_adc_sel,
    input wire logic [6:0] port_d_adc_sel,
    input wire logic conv_irq,
    input wire logic wake_request
);
    import adc_pkg::*;
    // ====================================================================
    // assertions
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    wake_tie_a: assert property (wake_request == conv_irq)
        else $error("wake differs from irq");
    power_off_a: assert property (analog_ctl.channel == CHAN_POWER_OFF |-> !analog_ctl.power_on)
        else $error("converter on in off code");
    stop_idle_a: assert property (stop_mode [*2] |-> !analog_ctl.power_on && !analog_ctl.sample)
        else $error("converter busy in stop");
    irq_clear_a: assert property (reg_req.rd && reg_req.addr == ADDR_RESULT && !analog_ctl.trial_code[0]
        |=> !conv_irq) else $error("irq kept after result read");
    first_trial_a: assert property ($fell(analog_ctl.sample) && analog_ctl.power_on
        && !$past(reg_req.wr) && !$past(stop_mode) |-> analog_ctl.trial_code == TRIAL_FIRST)
        else $error("first trial not msb");
    sample_quiet_a: assert property (analog_ctl.sample |-> analog_ctl.trial_code == 8'h00)
        else $error("trial code during sample");
    pin_b_a: assert property (analog_ctl.power_on && analog_ctl.channel <= CHAN_PORT_B_LAST
        |-> port_b_adc_sel == 8'h01 << analog_ctl.channel && port_d_adc_sel == 7'h00)
        else $error("port b select wrong");
    pin_d_a: assert property (analog_ctl.power_on && analog_ctl.channel inside
        {[CHAN_PORT_D_FIRST:CHAN_PORT_D_LAST]} |-> port_b_adc_sel == 8'h00
        && port_d_adc_sel == 7'h01 << (analog_ctl.channel - CHAN_PORT_D_FIRST))
        else $error("port d select wrong");
    pin_none_a: assert property (analog_ctl.channel > CHAN_PORT_D_LAST
        |-> port_b_adc_sel == 8'h00 && port_d_adc_sel == 7'h00) else $error("pin selected by internal code");
endmodule // adc_seq_sva

bind adc_sequencer_control adc_seq_sva chk (.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req),
    .stop_mode(stop_mode), .analog_ctl(analog_ctl), .port_b_adc_sel(port_b_adc_sel),
    .port_d_adc_sel(port_d_adc_sel), .conv_irq(conv_irq), .wake_request(wake_request));

// *** tb/adc_analog_model.sv ***
// analog input and comparator model on the converter side
`timescale 1ns/1ps
module adc_analog_model
    import adc_pkg::*;
(
    // clock and control from the sequencer, bias from the bench
    input wire logic mclk,
    input wire adc_pkg::analog_ctl_t analog_ctl,
    input wire logic [7:0] bias,
    // comparator result
    output logic comparator_high
);
    logic [7:0] level;
    logic junk_reg = 1'b0;
    // input level: references at the ends, port pins from code and bias
    always_comb
    begin
        if (analog_ctl.channel == CHAN_REF_HIGH) level = 8'hFF;
        else if (analog_ctl.channel == CHAN_REF_LOW) level = 8'h00;
        else level = {analog_ctl.channel[3:0], analog_ctl.channel[3:0]} ^ bias;
    end
    // toggling junk outside trials so nothing relies on a stale answer
    always_ff @(posedge mclk)
    begin
        junk_reg <= ~junk_reg;
    end
    // compare the held input against the trial code
    assign comparator_high = (analog_ctl.power_on && analog_ctl.trial_code != 8'h00) ?
        (level >= analog_ctl.trial_code) : junk_reg;
endmodule // adc_analog_model

// *** tb/adc_sequencer_control_bench.sv ***
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, e, g)
module adc_sequencer_control_bench;
    import adc_pkg::*;
    typedef struct packed {logic [2:0] code; logic src; int div; logic [4:0] chan;} row_t;
    logic mclk, rst_n, osc_tick, wait_mode, stop_mode, comparator_high, conv_irq, wake_request;
    reg_req_t reg_req;
    analog_ctl_t analog_ctl;
    logic [7:0] reg_rdata, port_b_adc_sel, bias, d;
    logic [6:0] port_d_adc_sel;
    logic [1:0] osc_cnt = 2'h0;
    int errors = 0, tests_run = 0, n;
    row_t rows [7] = '{'{3'h0, 1'b1, 1, 5'h00}, '{3'h1, 1'b1, 2, 5'h07}, '{3'h2, 1'b1, 4, 5'h08},
        '{3'h3, 1'b1, 8, 5'h0E}, '{3'h4, 1'b1, 16, 5'h1D}, '{3'h7, 1'b1, 16, 5'h1E}, '{3'h0, 1'b0, 4, 5'h0A}};

    adc_sequencer_control dut (.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .osc_tick(osc_tick), .wait_mode(wait_mode), .stop_mode(stop_mode), .analog_ctl(analog_ctl),
        .comparator_high(comparator_high), .port_b_adc_sel(port_b_adc_sel), .port_d_adc_sel(port_d_adc_sel),
        .conv_irq(conv_irq), .wake_request(wake_request));
    adc_analog_model far (.mclk(mclk), .analog_ctl(analog_ctl), .bias(bias), .comparator_high(comparator_high));

    // ====================================================================
    // clock, oscillator tick every fourth cycle
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        osc_cnt <= osc_cnt + 2'h1;
        osc_tick <= (osc_cnt == 2'h3);
    end

    // ====================================================================
    // helpers
    function automatic logic [7:0] lvl(input logic [4:0] c);
        return (c == CHAN_REF_HIGH) ? 8'hFF : (c == CHAN_REF_LOW) ? 8'h00 : {c[3:0], c[3:0]} ^ bias;
    endfunction
    task automatic print_verdict(input logic hung);
        if (hung) errors++;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string s, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        reg_req.wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge mclk);
    endtask
    task automatic wait_irq(output int k);
        k = 0;
        do
        begin
            @(negedge mclk);
            k++;
        end
        while (conv_irq !== 1'b1 && k < 400);
        if (k >= 400) print_verdict(1'b1);
        @(posedge mclk);
    endtask
    task automatic poll_done;
        int k = 0;
        logic [7:0] s = 8'h00;
        while (s[DONE_BIT] !== 1'b1 && k < 100)
        begin
            rd(ADDR_STATUS_CONTROL, s);
            k++;
        end
        if (k >= 100) print_verdict(1'b1);
    endtask

    // ====================================================================
    // main sequence
    initial
    begin
        reg_req = '0;
        wait_mode = 1'b0;
        stop_mode = 1'b0;
        bias = 8'h3C;
        rst_n = 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        // table: prescale, source and channel per row, irq mode
        for (int i = 0; i < 7; i++)
        begin
            wr(ADDR_CLOCK_SELECT, {rows[i].code, rows[i].src, 4'h0});
            wr(ADDR_STATUS_CONTROL, {3'b010, rows[i].chan});
            wait_irq(n);
            `CHK("conv time", 1'b1, n >= 15 * rows[i].div + 1 && n <= 17 * rows[i].div + 2);
            rd(ADDR_STATUS_CONTROL, d);
            `CHK("status in irq mode", {3'b010, rows[i].chan}, d);
            rd(ADDR_RESULT, d);
            `CHK("result", lvl(rows[i].chan), d);
            `CHK("irq after read", 1'b0, conv_irq);
        end
        // single conversion with flag, once only
        wr(ADDR_CLOCK_SELECT, 8'h10);
        wr(ADDR_STATUS_CONTROL, 8'h03);
        poll_done;
        `CHK("no irq when disabled", 1'b0, conv_irq);
        rd(ADDR_RESULT, d);
        `CHK("single result", lvl(5'h03), d);
        repeat (60) @(posedge mclk);
        rd(ADDR_STATUS_CONTROL, d);
        `CHK("single once", 8'h03, d);
        wr(ADDR_STATUS_CONTROL, 8'h03);
        poll_done;
        wr(ADDR_STATUS_CONTROL, 8'h1F);
        rd(ADDR_STATUS_CONTROL, d);
        `CHK("flag cleared by write", 8'h1F, d);
        // continuous with flag: set after first only, result refreshed
        wr(ADDR_STATUS_CONTROL, 8'h25);
        poll_done;
        rd(ADDR_RESULT, d);
        `CHK("first continuous", lvl(5'h05), d);
        bias <= 8'hC3;
        repeat (60) @(posedge mclk);
        rd(ADDR_STATUS_CONTROL, d);
        `CHK("flag after first", 8'h25, d);
        rd(ADDR_RESULT, d);
        `CHK("refreshed result", lvl(5'h05), d);
        // continuous with irq during wait mode
        wait_mode <= 1'b1;
        wr(ADDR_STATUS_CONTROL, 8'h66);
        for (int j = 0; j < 3; j++)
        begin
            wait_irq(n);
            `CHK("wake", 1'b1, wake_request);
            rd(ADDR_RESULT, d);
            `CHK("irq per conversion", lvl(5'h06), d);
        end
        wr(ADDR_STATUS_CONTROL, 8'h1F);
        wait_mode <= 1'b0;
        // stop mid-conversion, resume on exit
        wr(ADDR_STATUS_CONTROL, 8'h42);
        repeat (4) @(posedge mclk);
        stop_mode <= 1'b1;
        repeat (40) @(posedge mclk);
        `CHK("no irq in stop", 1'b0, conv_irq);
        stop_mode <= 1'b0;
        wait_irq(n);
        rd(ADDR_RESULT, d);
        `CHK("result after stop", lvl(5'h02), d);
        // power-off code: no conversion
        wr(ADDR_STATUS_CONTROL, 8'h5F);
        repeat (60) @(posedge mclk);
        `CHK("off no irq", 1'b0, conv_irq);
        rd(ADDR_RESULT, d);
        `CHK("off result kept", lvl(5'h02), d);
        // reset in mid-run
        wr(ADDR_CLOCK_SELECT, 8'hF0);
        wr(ADDR_STATUS_CONTROL, 8'h60);
        rst_n <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        `CHK("irq reset", 1'b0, conv_irq);
        rd(ADDR_STATUS_CONTROL, d);
        `CHK("status reset", 8'h1F, d);
        rd(ADDR_CLOCK_SELECT, d);
        `CHK("clock reset", 8'h00, d);
        print_verdict(1'b0);
    end
endmodule // adc_sequencer_control_bench
